// file: rtl/rpo_top.sv
// Receive parallel output stage: packs decoded symbols onto the fabric
// bus with per-word flags, byte ordering and an AHB-Lite register file.
// Assumes hclk is the recovered parallel clock and the decoder inputs
// are synchronous to it; dec_valid marks one symbol beat.
//
// The placing of the registers and the AHB-Lite slave port were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "rpo_consts.svh"
module rpo_top
    import rpo_pkg::*;
#(
    parameter int NUM_WORDS = `RPO_NUM_WORDS,
    parameter int WORD_W    = `RPO_WORD_W
)
(
    input  wire logic         hclk,
    input  wire logic         hresetn,
    input  wire logic         hsel,
    input  wire logic [31:0]  haddr,
    input  wire logic [1:0]   htrans,
    input  wire logic         hwrite,
    input  wire logic [2:0]   hsize,
    input  wire logic [31:0]  hwdata,
    input  wire logic         hready,
    output logic              hreadyout,
    output logic              hresp,
    output logic [31:0]       hrdata,
    input  wire logic         dec_valid,
    input  wire logic [15:0]  dec_data,
    input  wire logic [1:0]   dec_ctl,
    input  wire logic [1:0]   dec_rd,
    input  wire logic [3:0]   dec_rm,
    input  wire logic         byteord_req,
    input  wire logic         rx_core_clk_in,
    input  wire logic         tx_core_clk_in,
    output logic              rx_pcs_clk,
    output logic              tx_pcs_clk,
    output logic [63:0]       rx_parallel_data,
    output logic [3:0]        rx_datak,
    output logic [3:0]        rx_runningdisp,
    output logic              rx_word_stb,
    output logic              irq
);

    if (NUM_WORDS != `RPO_NUM_WORDS || WORD_W != `RPO_WORD_W) begin : g_chk
        $error("rpo_top supports four 16-bit words only");
    end

    rpo_top_st_t st_ff;
    rpo_top_st_t nxt_st;

    rpo_ord_if ordc ();

    rpo_byteord u_byteord (
        .hclk    (hclk),
        .hresetn (hresetn),
        .ordp    (ordc)
    );

    // Configuration decode
    logic dword;
    logic deser;

    assign dword = st_ff.ctrl[`RPO_CTRL_DWORD];
    assign deser = st_ff.ctrl[`RPO_CTRL_DESER];

    assign ordc.req = byteord_req;
    assign ordc.en  = st_ff.ctrl[`RPO_CTRL_ORDEN];

    // Core clock selection; the caller must switch the select only while
    // both clocks are quiet, as this plain mux is not glitch free.
    assign rx_pcs_clk = st_ff.ctrl[`RPO_CTRL_RXCK] ? rx_core_clk_in
                                                    : hclk;
    assign tx_pcs_clk = st_ff.ctrl[`RPO_CTRL_TXCK] ? tx_core_clk_in
                                                    : hclk;

    // Current beat, one symbol per lane
    rpo_sym_t [1:0] raw;
    rpo_sym_t [1:0] cur;

    always_comb begin
        raw[0].rm   = dec_rm[1:0];
        raw[0].rd   = dec_rd[0];
        raw[0].ctl  = dec_ctl[0];
        raw[0].data = dec_data[7:0];
        raw[1].rm   = dec_rm[3:2];
        raw[1].rd   = dec_rd[1];
        raw[1].ctl  = dec_ctl[1];
        raw[1].data = dec_data[15:8];
        // Lane swap is the byte-order step when no pairing of beats exists and dword is set
        if (st_ff.swap && dword && !deser) begin
            cur[0] = raw[1];
            cur[1] = raw[0];
        end else begin
            cur = raw;
        end
    end

    // With the deserializer, two beats make one output word group, so the
    // bus updates at half the beat rate.
    logic load;

    assign load = deser ? (dec_valid & st_ff.have) : dec_valid;

    // Per-word source selection and packing
    logic [NUM_WORDS-1:0]        w_on;
    logic [NUM_WORDS-1:0]        w_k;
    logic [NUM_WORDS-1:0]        w_rd;
    logic [NUM_WORDS*WORD_W-1:0] w_bits;

    for (genvar i = 0; i < NUM_WORDS; i++) begin : g_word
        rpo_sym_t         s;
        logic             on;
        logic [WORD_W-1:0] b;

        always_comb begin
            case (i)
                0: begin
                    s  = deser ? st_ff.held[0] : cur[0];
                    on = 1'b1;
                end
                1: begin
                    s  = deser ? st_ff.held[1] : cur[1];
                    on = dword;
                end
                2: begin
                    s  = cur[0];
                    on = deser;
                end
                default: begin
                    s  = cur[1];
                    on = deser & dword;
                end
            endcase
            b = '0;
            b[`RPO_WD_DATA_LSB +: 8] = s.data;
            b[`RPO_WD_CTL]           = s.ctl;
            b[`RPO_WD_RM_LSB +: 2]   = s.rm;
            b[`RPO_WD_RD]            = s.rd;
            if (!on) begin
                b = '0;
            end
        end

        assign w_on[i]                  = on;
        assign w_k[i]                   = on & s.ctl;
        assign w_rd[i]                  = on & s.rd;
        assign w_bits[i*WORD_W +: WORD_W] = b;
    end

    // Rate-match events over the lanes that carry data this beat
    logic [`RPO_ST_W-1:0] ev;
    logic                 lane1_on;

    assign lane1_on = dword;

    always_comb begin
        ev = '0;
        ev[`RPO_ST_ORD] = ordc.pulse;
        if (dec_valid) begin
            if (raw[0].rm == `RPO_RM_DEL ||
                (lane1_on && raw[1].rm == `RPO_RM_DEL)) begin
                ev[`RPO_ST_DEL] = 1'b1;
            end
            if (raw[0].rm == `RPO_RM_INS ||
                (lane1_on && raw[1].rm == `RPO_RM_INS)) begin
                ev[`RPO_ST_INS] = 1'b1;
            end
            if (raw[0].rm == `RPO_RM_OVF ||
                (lane1_on && raw[1].rm == `RPO_RM_OVF)) begin
                ev[`RPO_ST_OVF] = 1'b1;
            end
        end
    end

    // AHB-Lite address phase
    logic take;

    assign take = hsel & htrans[1] & hready;

    // Register read mux, used while a read waits one cycle
    logic [31:0] rmux;

    always_comb begin
        rmux = 32'h0000_0000;
        case (st_ff.dp_addr)
            `RPO_OFF_CTRL: begin
                rmux[`RPO_CTRL_W-1:0] = st_ff.ctrl;
            end
            `RPO_OFF_STATUS: begin
                rmux[`RPO_ST_W-1:0] = st_ff.stat;
            end
            `RPO_OFF_MASK: begin
                rmux[`RPO_ST_W-1:0] = st_ff.mask;
            end
            `RPO_OFF_LIVE: begin
                rmux[`RPO_LIVE_RD_LSB +: 4] = st_ff.out_rd;
                rmux[`RPO_LIVE_K_LSB +: 4]  = st_ff.out_k;
                rmux[`RPO_LIVE_RM_LSB +: 4] = st_ff.last_rm;
            end
            `RPO_OFF_ORDCNT: begin
                rmux[`RPO_ORDCNT_W-1:0] = ordc.count;
            end
            default: begin
                rmux = 32'h0000_0000;
            end
        endcase
    end

    logic                 wr_ctrl;
    logic                 wr_stat;
    logic                 wr_mask;
    logic [`RPO_ST_W-1:0] clr;

    assign wr_ctrl = st_ff.dp_wr && st_ff.dp_addr == `RPO_OFF_CTRL;
    assign wr_stat = st_ff.dp_wr && st_ff.dp_addr == `RPO_OFF_STATUS;
    assign wr_mask = st_ff.dp_wr && st_ff.dp_addr == `RPO_OFF_MASK;
    assign clr     = wr_stat ? hwdata[`RPO_ST_W-1:0] : '0;

    always_comb begin
        nxt_st = st_ff;

        // Bus slave: writes in the data phase, reads take one wait cycle
        // so that a read right after a write sees the new value.
        if (st_ff.dp_rd && !st_ff.rd_done) begin
            nxt_st.rdata   = rmux;
            nxt_st.rd_done = 1'b1;
        end else begin
            nxt_st.dp_wr   = take & hwrite;
            nxt_st.dp_rd   = take & ~hwrite;
            nxt_st.rd_done = 1'b0;
            nxt_st.dp_addr = take ? {haddr[7:2], 2'b00} : st_ff.dp_addr;
        end
        if (wr_ctrl) begin
            nxt_st.ctrl = hwdata[`RPO_CTRL_W-1:0];
        end
        if (wr_mask) begin
            nxt_st.mask = hwdata[`RPO_ST_W-1:0];
        end
        // Write-one-to-clear, a new event in the same cycle wins
        nxt_st.stat = (st_ff.stat & ~clr) | ev;

        // Datapath
        nxt_st.stb = load;
        if (load) begin
            nxt_st.out_data = w_bits;
            nxt_st.out_k    = w_k;
            nxt_st.out_rd   = w_rd;
        end
        if (dec_valid) begin
            nxt_st.last_rm = dec_rm;
        end
        if (deser && dec_valid) begin
            if (st_ff.have) begin
                nxt_st.have = 1'b0;
            end else begin
                nxt_st.held = cur;
                nxt_st.have = 1'b1;
            end
        end
        if (!deser) begin
            nxt_st.have = 1'b0;
        end

        // Byte ordering: with pairing of beats it restarts the pairing so
        // the current beat leads; otherwise it toggles the lane swap, which applies only with dword set.
        if (ordc.pulse) begin
            if (deser) begin
                nxt_st.have = dec_valid;
                nxt_st.held = cur;
                nxt_st.stb  = 1'b0;
            end else begin
                nxt_st.swap = ~st_ff.swap;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_ff          <= '0;
            st_ff.ctrl     <= `RPO_CTRL_RESET;
            st_ff.mask     <= `RPO_MASK_RESET;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Outputs; every driven word is valid, the consumer has no back
    // pressure, so there is no ready input.
    assign rx_parallel_data = st_ff.out_data;
    assign rx_datak         = st_ff.out_k;
    assign rx_runningdisp   = st_ff.out_rd;
    assign rx_word_stb      = st_ff.stb;
    assign hreadyout        = ~(st_ff.dp_rd & ~st_ff.rd_done);
    assign hresp            = 1'b0;
    assign hrdata           = st_ff.rdata;
    assign irq              = |(st_ff.stat & st_ff.mask);

endmodule : rpo_top
`default_nettype wire

// file: rtl/rpo_consts.svh
// Constants of the receive parallel output block: offsets, fields, codes.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef RPO_CONSTS_SVH
`define RPO_CONSTS_SVH

// Register byte offsets
`define RPO_OFF_CTRL      8'h00
`define RPO_OFF_STATUS    8'h04
`define RPO_OFF_MASK      8'h08
`define RPO_OFF_LIVE      8'h0C
`define RPO_OFF_ORDCNT    8'h10

// Control register fields
`define RPO_CTRL_W        5
`define RPO_CTRL_DWORD    0
`define RPO_CTRL_DESER    1
`define RPO_CTRL_ORDEN    2
`define RPO_CTRL_RXCK     3
`define RPO_CTRL_TXCK     4
`define RPO_CTRL_RESET    5'h00

// Status and mask fields
`define RPO_ST_W          4
`define RPO_ST_ORD        0
`define RPO_ST_DEL        1
`define RPO_ST_INS        2
`define RPO_ST_OVF        3
`define RPO_MASK_RESET    4'h0

// Rate-match codes
`define RPO_RM_NORMAL     2'b00
`define RPO_RM_DEL        2'b01
`define RPO_RM_INS        2'b10
`define RPO_RM_OVF        2'b11

// Output word layout
`define RPO_WD_DATA_LSB   0
`define RPO_WD_CTL        8
`define RPO_WD_RM_LSB     13
`define RPO_WD_RD         15

// Live register layout
`define RPO_LIVE_RD_LSB   0
`define RPO_LIVE_K_LSB    4
`define RPO_LIVE_RM_LSB   8

`define RPO_ORDCNT_W      8
`define RPO_NUM_WORDS     4
`define RPO_WORD_W        16

`endif

// file: rtl/rpo_pkg.sv
// Types shared by the receive parallel output modules.
// Assumes rpo_consts.svh is on the include path.
`include "rpo_consts.svh"
package rpo_pkg;

    typedef struct packed {
        logic [1:0] rm;
        logic       rd;
        logic       ctl;
        logic [7:0] data;
    } rpo_sym_t;

    typedef enum logic [1:0] {
        ORD_IDLE = 2'b00,
        ORD_RUN  = 2'b01,
        ORD_HOLD = 2'b11
    } rpo_ord_state_t;

    typedef struct packed {
        rpo_ord_state_t            st;
        logic                      req_d;
        logic                      pulse;
        logic [`RPO_ORDCNT_W-1:0]  cnt;
    } rpo_ord_st_t;

    typedef struct packed {
        logic [`RPO_CTRL_W-1:0]    ctrl;
        logic [`RPO_ST_W-1:0]      stat;
        logic [`RPO_ST_W-1:0]      mask;
        logic                      dp_wr;
        logic                      dp_rd;
        logic                      rd_done;
        logic [7:0]                dp_addr;
        logic [31:0]               rdata;
        logic                      have;
        logic                      swap;
        rpo_sym_t [1:0]            held;
        logic [63:0]               out_data;
        logic [3:0]                out_k;
        logic [3:0]                out_rd;
        logic                      stb;
        logic [3:0]                last_rm;
    } rpo_top_st_t;

endpackage : rpo_pkg

// file: rtl/rpo_ord_if.sv
// Interface between the output top and its byte-order request tracker.
// Assumes both ends run on the same parallel clock.
`timescale 1ns/100ps
`default_nettype none
`include "rpo_consts.svh"
interface rpo_ord_if;
    logic                      req;
    logic                      en;
    logic                      pulse;
    logic [`RPO_ORDCNT_W-1:0]  count;

    modport ctl (output req, output en, input pulse, input count);
    modport ord (input req, input en, output pulse, output count);
endinterface : rpo_ord_if
`default_nettype wire

// file: rtl/rpo_byteord.sv
// Byte-order request tracker: one ordering pulse per request assertion.
// Assumes the request is synchronous to hclk.
`timescale 1ns/100ps
`default_nettype none
`include "rpo_consts.svh"
module rpo_byteord
    import rpo_pkg::*;
(
    input  wire logic  hclk,
    input  wire logic  hresetn,
    rpo_ord_if.ord     ordp
);

    rpo_ord_st_t st_ff;
    rpo_ord_st_t nxt_st;
    logic        rise;

    assign rise = ordp.req & ~st_ff.req_d;

    always_comb begin
        nxt_st       = st_ff;
        nxt_st.req_d = ordp.req;
        nxt_st.pulse = 1'b0;
        case (st_ff.st)
            ORD_IDLE: begin
                if (rise && ordp.en) begin
                    nxt_st.st    = ORD_RUN;
                    nxt_st.pulse = 1'b1;
                    nxt_st.cnt   = st_ff.cnt + 1'b1;
                end
            end
            ORD_RUN: begin
                nxt_st.st = ORD_HOLD;
            end
            ORD_HOLD: begin
                // Holding the request does not repeat it
                if (!ordp.req) begin
                    nxt_st.st = ORD_IDLE;
                end
            end
            default: begin
                nxt_st.st = ORD_IDLE;
            end
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_ff <= '{st: ORD_IDLE, req_d: 1'b0, pulse: 1'b0, cnt: '0};
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign ordp.pulse = st_ff.pulse;
    assign ordp.count = st_ff.cnt;

endmodule : rpo_byteord
`default_nettype wire

// file: verification/rpo_monitor.sv
// Port checker for the receive parallel output stage.
// Assumes it is bound into rpo_top and sees hclk only.
`timescale 1ns/100ps
`default_nettype none
module rpo_monitor
(
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic        dec_valid,
    input wire logic        rx_core_clk_in,
    input wire logic        rx_pcs_clk,
    input wire logic [63:0] rx_parallel_data,
    input wire logic [3:0]  rx_datak,
    input wire logic [3:0]  rx_runningdisp,
    input wire logic        rx_word_stb
);
    logic [63:0] d;
    assign d = rx_parallel_data;
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    a_stb_after_beat: assert property (rx_word_stb |-> $past(dec_valid))
        else $error("word strobe without a decoded beat");
    a_bus_holds: assert property (!rx_word_stb |-> $stable(d))
        else $error("output bus changed without strobe");
    a_ctl_flag_copy: assert property (rx_datak == {d[56], d[40], d[24], d[8]})
        else $error("control flags differ from word bit 8");
    a_disp_flag_copy: assert property (rx_runningdisp == {d[63], d[47], d[31], d[15]})
        else $error("disparity flags differ from word bit 15");
    a_spare_zero: assert property ({d[60:57], d[44:41], d[28:25], d[12:9]} == 16'h0)
        else $error("spare word bits not zero");
    a_write_nowait: assert property (hsel && htrans[1] && hready && hwrite |=> hreadyout)
        else $error("write data phase stalled");
    a_read_wait: assert property (hsel && htrans[1] && hready && !hwrite |=> !hreadyout ##1 hreadyout)
        else $error("read data phase not one wait state");
    a_resp_okay: assert property (hresp == 1'b0)
        else $error("response not okay");
    a_core_clk_mux: assert property (rx_pcs_clk == hclk || rx_pcs_clk == rx_core_clk_in)
        else $error("receive core clock is neither source");
endmodule : rpo_monitor
bind rpo_top rpo_monitor rpo_monitor_inst (.hclk, .hresetn, .hsel, .htrans,
    .hwrite, .hready, .hreadyout, .hresp, .dec_valid, .rx_core_clk_in,
    .rx_pcs_clk, .rx_parallel_data, .rx_datak, .rx_runningdisp, .rx_word_stb);
`default_nettype wire

// file: verification/rpo_mac_model.sv
// Fabric-side consumer model of the receive words.
// Assumes the stage's clock and reset; it cannot stall the stage.
`timescale 1ns/100ps
`default_nettype none
module rpo_mac_model
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        rx_word_stb,
    input  wire logic [63:0] rx_parallel_data,
    output var  logic [63:0] last_word,
    output var  int          word_cnt
);
    // No ready path exists, so a word is taken in its strobe cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            last_word <= 64'h0;
            word_cnt  <= 0;
        end else if (rx_word_stb) begin
            last_word <= rx_parallel_data;
            word_cnt  <= word_cnt + 1;
        end
    end
endmodule : rpo_mac_model
`default_nettype wire

// file: verification/test_rx_pcs_parallel_output.sv
// Bench for the receive parallel output stage over AHB-Lite.
// Assumes rpo_top, rpo_mac_model and the bound monitor.
`timescale 1ns/100ps
`default_nettype none
`include "rpo_consts.svh"
module test_rx_pcs_parallel_output;
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [2:0]  hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic        dec_valid = 1'b0;
    logic [15:0] dec_data = 16'h0;
    logic [1:0]  dec_ctl = 2'h0;
    logic [1:0]  dec_rd = 2'h0;
    logic [3:0]  dec_rm = 4'h0;
    logic        byteord_req = 1'b0;
    logic        rx_core_clk_in = 1'b0;
    logic        tx_core_clk_in = 1'b1;
    wire         hreadyout, hresp, rx_pcs_clk, tx_pcs_clk, rx_word_stb, irq;
    wire [31:0]  hrdata;
    wire [63:0]  rx_parallel_data;
    wire [3:0]   rx_datak, rx_runningdisp;
    logic [63:0] last_word;
    logic [31:0] rv;
    int          word_cnt, error_cnt = 0, compares = 0, k, n0;

    rpo_top rpo_top_inst (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
        .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata,
        .dec_valid, .dec_data, .dec_ctl, .dec_rd, .dec_rm, .byteord_req,
        .rx_core_clk_in, .tx_core_clk_in, .rx_pcs_clk, .tx_pcs_clk,
        .rx_parallel_data, .rx_datak, .rx_runningdisp, .rx_word_stb, .irq);
    rpo_mac_model rpo_mac_model_inst (.hclk, .hresetn, .rx_word_stb,
        .rx_parallel_data, .last_word, .word_cnt);

    initial begin
        forever #2 hclk = ~hclk;
    end
    // Core clocks at half rate, out of step with each other
    always @(posedge hclk) begin
        rx_core_clk_in <= ~rx_core_clk_in;
        tx_core_clk_in <= ~tx_core_clk_in;
    end

    task automatic stop_test;
        $display("compares %0d error_cnt %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : stop_test

    task automatic check(string n, logic [63:0] seen, logic [63:0] exp);
        compares++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", n, exp, seen);
        end
    endtask : check

    task automatic hang(string n);
        error_cnt++;
        $display("ERROR %s timed out", n);
        stop_test();
    endtask : hang

    task automatic ahb(logic wr, logic [7:0] a, logic [31:0] wd);
        int i;
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= {24'h0, a};
        for (i = 0; i < 16; i++) begin
            @(posedge hclk);
            if (hreadyout === 1'b1) break;
        end
        if (i == 16) hang("bus address");
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        for (i = 0; i < 16; i++) begin
            @(posedge hclk);
            if (hreadyout === 1'b1) break;
        end
        if (i == 16) hang("bus");
        rv = hrdata;
    endtask : ahb

    task automatic wr(logic [7:0] a, logic [31:0] v);
        ahb(1'b1, a, v);
    endtask : wr

    task automatic rd_chk(string n, logic [7:0] a, logic [31:0] e);
        ahb(1'b0, a, 32'h0);
        check(n, {32'h0, rv}, {32'h0, e});
    endtask : rd_chk

    task automatic irq_chk(logic e);
        @(posedge hclk);
        #1;
        check("irq", {63'h0, irq}, {63'h0, e});
    endtask : irq_chk

    task automatic beat(logic [15:0] dd, logic [1:0] c, r, logic [3:0] m);
        @(posedge hclk);
        dec_valid <= 1'b1;
        dec_data <= dd;
        dec_ctl <= c;
        dec_rd <= r;
        dec_rm <= m;
    endtask : beat

    task automatic got(string n, logic [63:0] e);
        int i;
        @(posedge hclk);
        dec_valid <= 1'b0;
        for (i = 0; i < 8 && rx_word_stb !== 1'b1; i++) @(posedge hclk);
        if (i == 8) hang(n);
        #1;
        check(n, last_word, e);
    endtask : got

    function automatic logic [15:0] wd(logic [7:0] d, logic c,
                                       logic [1:0] m, logic r);
        return {r, m, 4'h0, c, d};
    endfunction : wd

    initial begin
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        rd_chk("ctrl", `RPO_OFF_CTRL, 32'h0);
        rd_chk("unmapped", 8'h20, 32'h0);
        for (k = 0; k < 4; k++) begin
            beat({8'h5a, 8'h30 + k[7:0]}, {1'b0, k[0]}, {1'b0, k[1]},
                 {2'h0, k[1:0]});
            got("single", {48'h0, wd(8'h30 + k[7:0], k[0], k[1:0], k[1])});
        end
        rd_chk("rm events", `RPO_OFF_STATUS, 32'he);
        wr(`RPO_OFF_STATUS, 32'hf);
        $display("test single done");
        wr(`RPO_OFF_CTRL, 32'h1);
        beat({8'ha1, 8'hb2}, 2'h2, 2'h1, 4'h4);
        got("double", {32'h0, wd(8'ha1, 1, 1, 0), wd(8'hb2, 0, 0, 1)});
        check("datak", {60'h0, rx_datak}, 64'h2);
        check("disp", {60'h0, rx_runningdisp}, 64'h1);
        rd_chk("live", `RPO_OFF_LIVE, 32'h0000_0421);
        rd_chk("lane1 rm", `RPO_OFF_STATUS, 32'h2);
        wr(`RPO_OFF_STATUS, 32'hf);
        wr(`RPO_OFF_CTRL, 32'h2);
        beat(16'h1122, 2'h0, 2'h0, 4'h0);
        beat(16'h3344, 2'h1, 2'h1, 4'h0);
        got("single deser", {16'h0, wd(8'h44, 1, 0, 1), 16'h0, wd(8'h22, 0, 0, 0)});
        wr(`RPO_OFF_CTRL, 32'h3);
        n0 = word_cnt;
        beat(16'h1122, 2'h0, 2'h0, 4'h0);
        beat(16'h3344, 2'h1, 2'h1, 4'h0);
        got("double deser", {wd(8'h33, 0, 0, 0), wd(8'h44, 1, 0, 1),
            wd(8'h11, 0, 0, 0), wd(8'h22, 0, 0, 0)});
        check("half rate", 64'(word_cnt - n0), 64'h1);
        $display("test layout done");
        wr(`RPO_OFF_CTRL, 32'h1);
        byteord_req <= 1'b1;
        repeat (3) @(posedge hclk);
        byteord_req <= 1'b0;
        rd_chk("ord off", `RPO_OFF_ORDCNT, 32'h0);
        wr(`RPO_OFF_CTRL, 32'h5);
        byteord_req <= 1'b1;
        repeat (8) @(posedge hclk);
        rd_chk("ord once", `RPO_OFF_ORDCNT, 32'h1);
        rd_chk("ord done", `RPO_OFF_STATUS, 32'h1);
        wr(`RPO_OFF_MASK, 32'h1);
        irq_chk(1'b1);
        wr(`RPO_OFF_MASK, 32'h0);
        irq_chk(1'b0);
        beat({8'ha1, 8'hb2}, 2'h2, 2'h1, 4'h0);
        got("swapped", {32'h0, wd(8'hb2, 0, 0, 1), wd(8'ha1, 1, 0, 0)});
        // Drop then raise again for a second operation
        byteord_req <= 1'b0;
        repeat (3) @(posedge hclk);
        byteord_req <= 1'b1;
        repeat (4) @(posedge hclk);
        byteord_req <= 1'b0;
        rd_chk("ord twice", `RPO_OFF_ORDCNT, 32'h2);
        wr(`RPO_OFF_MASK, 32'h1);
        wr(`RPO_OFF_STATUS, 32'h1);
        rd_chk("ord clear", `RPO_OFF_STATUS, 32'h0);
        irq_chk(1'b0);
        $display("test byte order done");
        wr(`RPO_OFF_CTRL, 32'h18);
        for (k = 0; k < 2; k++) begin
            @(posedge hclk);
            #1;
            check("rx core", {63'h0, rx_pcs_clk}, {63'h0, rx_core_clk_in});
            check("tx core", {63'h0, tx_pcs_clk}, {63'h0, tx_core_clk_in});
        end
        wr(`RPO_OFF_CTRL, 32'h0);
        @(posedge hclk);
        #1;
        check("rx own clk", {63'h0, rx_pcs_clk}, {63'h0, hclk});
        $display("test clocks done");
        stop_test();
    end
endmodule : test_rx_pcs_parallel_output
`default_nettype wire
